/* File: mfr_engine.sv */
// multi-lane fast-read engine: dual/quad output, dual/quad io, opcode skip, burst wrap
// assumes sclk, cs_n and io_in come from the host pins (asynchronous to hclk),
// and the array returns mem_rdata for mem_raddr one hclk after the address changes
//
// Overview of operation
// R1 - 3Bh: address on io0, 8 dummies, dual out
// R2 - host releases io0 before first data
// R3 - 6Bh quad out, only with quad enable
// R4 - host sends 8 dummies, then tristates
// R5 - BBh: address and data on two lanes
// R6 - mode byte follows address; low nibble ignored
// R7 - mode bits 10: next dual read skips opcode
// R8 - other mode bits: full opcode next time
// R9 - host drives ones to leave dual skip
// R10 - EBh four lanes, 4 dummies single-lane mode
// R11 - quad io read needs quad enable
// R12 - mode bits 10: next quad read skips opcode
// R13 - host drives ones to leave quad skip
// R14 - wrap inside aligned section in single-lane mode
// R15 - wrap bits: disable bit, two length bits
// R16 - four-lane dummies 2/4/6/8, default 2
// R17 - four-lane: mode byte counts as dummies
// R18 - opcode skip also in four-lane mode
// R19 - four-lane quad io read never wraps
// R20 - 3Bh/6Bh/BBh only in single-lane mode
// R21 - address increments after each byte
// R22 - select high ends any read
// R23 - data msb first on falling, input rising
// R24 - highest io line carries the msb
// R25 - wrap section aligned to its length
//
// Register access over AHB-Lite and the register addresses were decided locally.
module mfr_engine (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic [3:0]  io_in,
    output logic [3:0]       io_out,
    output logic [3:0]       io_oe,
    output logic [23:0]      mem_raddr,
    input  wire logic [7:0]  mem_rdata
);
    typedef struct packed {
        logic                sclk_s1;
        logic                sclk_s2;
        logic                sclk_s3;
        logic                cs_s1;
        logic                cs_s2;
        logic [3:0]          io_s1;
        logic [3:0]          io_s2;
        mfr_pkg::mfr_state_e st;
        logic [7:0]          op;
        logic [2:0]          lanes;
        logic [2:0]          olanes;
        logic [4:0]          cnt;
        logic [23:0]         sh;
        logic [23:0]         addr;
        logic                wrap_en;
        logic [7:0]          dsh;
        logic [2:0]          dcnt;
        logic                cont;
        logic                qe;
        logic                four_lane_command_mode;
        logic [2:0]          wrap;
        logic [1:0]          rpar;
        logic [3:0]          io_out;
        logic [3:0]          io_oe;
        logic [31:0]         hrdata;
        logic                hreadyout;
        logic                hresp;
        logic                dp_wr;
        logic [7:0]          dp_addr;
    } mfr_state_s;

    mfr_state_s r;
    mfr_state_s n;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // R24 high lane is msb
    function automatic logic [23:0] shift_in(input logic [23:0] s, input logic [2:0] w,
                                             input logic [3:0] io);
        unique case (w)
            3'h2:    shift_in = {s[21:0], io[1:0]};
            3'h4:    shift_in = {s[19:0], io[3:0]};
            default: shift_in = {s[22:0], io[0]};
        endcase
    endfunction

    // R25 aligned section wrap
    function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wen,
                                              input logic [1:0] len);
        logic [23:0] m;
        logic [23:0] inc;
        m   = (24'h8 << len) - 24'h1;
        inc = a + 24'h1;
        // R14 wrap stays in section
        next_addr = wen ? ((a & ~m) | (inc & m)) : inc;
    endfunction

    function automatic logic [3:0] lane_bits(input logic [7:0] b, input logic [2:0] w);
        unique case (w)
            3'h2:    lane_bits = {2'h0, b[7:6]};
            3'h4:    lane_bits = b[7:4];
            default: lane_bits = {2'h0, b[7], 1'b0};
        endcase
    endfunction

    function automatic logic [3:0] lane_mask(input logic [2:0] w);
        unique case (w)
            3'h2:    lane_mask = 4'h3;
            3'h4:    lane_mask = 4'hf;
            default: lane_mask = 4'h2;
        endcase
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic        rise;
    logic        fall;
    logic        addr_ph;
    logic [4:0]  cnt_add;
    logic [4:0]  dum;
    logic [7:0]  byte_w;

    always_comb begin
        n       = r;
        rise    = r.sclk_s2 & ~r.sclk_s3;
        fall    = ~r.sclk_s2 & r.sclk_s3;
        cnt_add = r.cnt + {2'h0, r.lanes};
        dum     = 5'h0;
        byte_w  = 8'h0;
        addr_ph = hsel & htrans[1] & hready;

        // two flops on every host pin before any logic looks at it
        n.sclk_s1 = sclk;
        n.sclk_s2 = r.sclk_s1;
        n.sclk_s3 = r.sclk_s2;
        n.cs_s1   = cs_n;
        n.cs_s2   = r.cs_s1;
        n.io_s1   = io_in;
        n.io_s2   = r.io_s1;

        // link sequencer
        // R22 select high ends read
        if (r.cs_s2) begin
            n.st    = mfr_pkg::ST_IDLE;
            n.io_oe = 4'h0;
        end else begin
            unique case (r.st)
                mfr_pkg::ST_IDLE: begin
                    n.cnt  = 5'h0;
                    n.dcnt = 3'h0;
                    // R7 R12 R18 opcode skipped
                    if (r.cont) begin
                        n.st = mfr_pkg::ST_ADDR;
                    end else begin
                        n.st    = mfr_pkg::ST_CMD;
                        n.lanes = r.four_lane_command_mode ? 3'h4 : 3'h1;
                    end
                end
                mfr_pkg::ST_CMD: if (rise) begin
                    // R23 sample on rising
                    n.sh  = shift_in(r.sh, r.lanes, r.io_s2);
                    n.cnt = cnt_add;
                    if (cnt_add == mfr_pkg::CMD_BITS) begin
                        n.op  = n.sh[7:0];
                        n.cnt = 5'h0;
                        n.st  = mfr_pkg::ST_SKIP;
                        unique case (n.sh[7:0])
                            // R1 R20 dual out
                            mfr_pkg::OP_DUAL_OUT: if (!r.four_lane_command_mode) begin
                                n.st     = mfr_pkg::ST_ADDR;
                                n.olanes = 3'h2;
                            end
                            // R3 R20 quad out gated
                            mfr_pkg::OP_QUAD_OUT: if (!r.four_lane_command_mode && r.qe) begin
                                n.st     = mfr_pkg::ST_ADDR;
                                n.olanes = 3'h4;
                            end
                            // R5 R20 dual io
                            mfr_pkg::OP_DUAL_IO: if (!r.four_lane_command_mode) begin
                                n.st     = mfr_pkg::ST_ADDR;
                                n.lanes  = 3'h2;
                                n.olanes = 3'h2;
                            end
                            // R10 R11 quad io gated
                            mfr_pkg::OP_QUAD_IO: if (r.qe) begin
                                n.st     = mfr_pkg::ST_ADDR;
                                n.lanes  = 3'h4;
                                n.olanes = 3'h4;
                            end
                            default: n.st = mfr_pkg::ST_SKIP;
                        endcase
                    end
                end
                mfr_pkg::ST_ADDR: if (rise) begin
                    n.sh  = shift_in(r.sh, r.lanes, r.io_s2);
                    n.cnt = cnt_add;
                    if (cnt_add == mfr_pkg::ADDR_BITS) begin
                        n.addr = n.sh;
                        n.cnt  = 5'h0;
                        // R19 no wrap in four-lane mode
                        n.wrap_en = (r.op == mfr_pkg::OP_QUAD_IO) && !r.four_lane_command_mode && !r.wrap[0];
                        // R6 mode byte after io address
                        if (r.op == mfr_pkg::OP_DUAL_IO || r.op == mfr_pkg::OP_QUAD_IO) begin
                            n.st = mfr_pkg::ST_MODE;
                        end else begin
                            n.st = mfr_pkg::ST_DUMMY;
                        end
                    end
                end
                mfr_pkg::ST_MODE: if (rise) begin
                    n.sh  = shift_in(r.sh, r.lanes, r.io_s2);
                    n.cnt = cnt_add;
                    if (cnt_add == mfr_pkg::MODE_BITS) begin
                        n.cnt = 5'h0;
                        // R6 R8 only bits 5 and 4 decide
                        n.cont = (n.sh[5:4] == mfr_pkg::SKIP_CODE);
                        // R16 R17 mode clocks are part of the dummies
                        if (r.op == mfr_pkg::OP_DUAL_IO) begin
                            dum = 5'h0;
                        end else if (r.four_lane_command_mode) begin
                            dum = {2'h0, r.rpar, 1'b0};
                        end else begin
                            dum = mfr_pkg::DUMMY_QIO_SPI;
                        end
                        n.sh[4:0] = dum;
                        n.st      = (dum == 5'h0) ? mfr_pkg::ST_DATA : mfr_pkg::ST_DUMMY;
                    end
                end
                mfr_pkg::ST_DUMMY: if (rise) begin
                    n.cnt = r.cnt + 5'h1;
                    // R1 R4 eight dummies for output reads
                    dum = (r.op == mfr_pkg::OP_DUAL_OUT || r.op == mfr_pkg::OP_QUAD_OUT) ?
                          mfr_pkg::DUMMY_FAST : r.sh[4:0];
                    if (r.cnt + 5'h1 == dum) begin
                        n.st = mfr_pkg::ST_DATA;
                    end
                end
                mfr_pkg::ST_DATA: if (fall) begin
                    // R23 msb first on falling edge
                    byte_w  = (r.dcnt == 3'h0) ? mem_rdata : r.dsh;
                    n.io_out = lane_bits(byte_w, r.olanes);
                    n.io_oe  = lane_mask(r.olanes);
                    n.dsh    = byte_w << r.olanes;
                    n.dcnt   = r.dcnt + r.olanes;
                    // R21 next byte fetched at byte start
                    if (r.dcnt == 3'h0) begin
                        n.addr = next_addr(r.addr, r.wrap_en, r.wrap[2:1]);
                    end
                end
                mfr_pkg::ST_SKIP: n.io_oe = 4'h0;
                default:          n.st = mfr_pkg::ST_IDLE;
            endcase
        end

        // register bus: write lands in the data phase
        if (r.dp_wr && r.dp_addr == mfr_pkg::CFG_OFS) begin
            n.qe   = hwdata[mfr_pkg::QE_POS];
            n.four_lane_command_mode  = hwdata[mfr_pkg::QPI_POS];
            // R15 wrap bits steer later quad io reads
            n.wrap = hwdata[mfr_pkg::WRAP_LSB +: 3];
            n.rpar = hwdata[mfr_pkg::RPAR_LSB +: 2];
            // R16 reset instruction restores two dummies
            if (hwdata[mfr_pkg::SRST_POS]) begin
                n.rpar = mfr_pkg::RPAR_RST;
                n.cont = 1'b0;
            end
        end
        n.dp_wr   = addr_ph & hwrite;
        n.dp_addr = haddr[7:0];
        n.hrdata  = 32'h0;
        if (addr_ph && !hwrite) begin
            unique case (haddr[7:0])
                mfr_pkg::CFG_OFS: begin
                    n.hrdata[mfr_pkg::QE_POS]         = r.qe;
                    n.hrdata[mfr_pkg::QPI_POS]        = r.four_lane_command_mode;
                    n.hrdata[mfr_pkg::WRAP_LSB +: 3]  = r.wrap;
                    n.hrdata[mfr_pkg::RPAR_LSB +: 2]  = r.rpar;
                end
                mfr_pkg::STAT_OFS: begin
                    n.hrdata[2:0]                     = r.st;
                    n.hrdata[mfr_pkg::CONT_POS]       = r.cont;
                    n.hrdata[mfr_pkg::OP_LSB +: 8]    = r.op;
                end
                default: n.hrdata = 32'h0;
            endcase
        end
        n.hreadyout = 1'b1;
        n.hresp     = 1'b0;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r           <= '0;
            r.sclk_s1   <= 1'b0;
            r.cs_s1     <= 1'b1;
            r.cs_s2     <= 1'b1;
            r.st        <= mfr_pkg::ST_IDLE;
            r.lanes     <= 3'h1;
            r.olanes    <= 3'h2;
            r.wrap      <= mfr_pkg::WRAP_RST;
            r.rpar      <= mfr_pkg::RPAR_RST;
            r.hreadyout <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign hreadyout = r.hreadyout;
    assign hresp     = r.hresp;
    assign hrdata    = r.hrdata;
    assign io_out    = r.io_out;
    assign io_oe     = r.io_oe;
    assign mem_raddr = r.addr;
endmodule

/* File: mfr_pkg.sv */
// package for the multi-lane fast-read engine: offsets, reset values, opcodes, counts
// assumes one AHB-Lite slave on hclk and a byte-wide array read port with one hclk latency
package mfr_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  CFG_OFS       = 8'h00;
    localparam logic [7:0]  STAT_OFS      = 8'h04;
    localparam int          QE_POS        = 0;
    localparam int          QPI_POS       = 1;
    localparam int          WRAP_LSB      = 4;
    localparam int          RPAR_LSB      = 8;
    localparam int          SRST_POS      = 31;
    localparam int          CONT_POS      = 3;
    localparam int          OP_LSB        = 8;
    localparam logic [2:0]  WRAP_RST      = 3'h1;
    localparam logic [1:0]  RPAR_RST      = 2'h0;

    // ------------------------------------------------------------
    // link command set and counts
    // ------------------------------------------------------------
    localparam logic [7:0]  OP_DUAL_OUT   = 8'h3b;
    localparam logic [7:0]  OP_QUAD_OUT   = 8'h6b;
    localparam logic [7:0]  OP_DUAL_IO    = 8'hbb;
    localparam logic [7:0]  OP_QUAD_IO    = 8'heb;
    localparam logic [4:0]  CMD_BITS      = 5'h08;
    localparam logic [4:0]  ADDR_BITS     = 5'h18;
    localparam logic [4:0]  MODE_BITS     = 5'h08;
    localparam logic [4:0]  DUMMY_FAST    = 5'h08;
    localparam logic [4:0]  DUMMY_QIO_SPI = 5'h04;
    localparam logic [1:0]  SKIP_CODE     = 2'h2;
    localparam logic [8:0]  PAGE_BYTES    = 9'h100;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CMD   = 3'b001,
        ST_ADDR  = 3'b010,
        ST_MODE  = 3'b011,
        ST_DUMMY = 3'b100,
        ST_DATA  = 3'b101,
        ST_SKIP  = 3'b110
    } mfr_state_e;
endpackage

/* File: mfr_engine_sva.sv */
// checker for the fast-read engine, watching the top ports only
// assumes one hclk domain; bound from the bench top file
module mfr_engine_sva (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic [3:0]  io_in,
    input wire logic [3:0]  io_out,
    input wire logic [3:0]  io_oe,
    input wire logic [23:0] mem_raddr,
    input wire logic [7:0]  mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // cycles since the link clock fell
    // ------
    logic       sclk_d_r;
    logic [3:0] since_fall_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_d_r     <= 1'b0;
            since_fall_r <= 4'hf;
        end else begin
            sclk_d_r     <= sclk;
            since_fall_r <= (sclk_d_r && !sclk) ? 4'h0 : since_fall_r + {3'h0, since_fall_r != 4'hf};
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd_req;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_desel;
        cs_n [*6];
    endsequence
    a_zero_wait: assert property (hreadyout && !hresp) else $error("slave stalled or erred");
    a_rdata_idle: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0)
        else $error("read data outside a data phase");
    a_rdata_unmapped: assert property (s_rd_req ##0 (haddr[7:0] >= 8'h08) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_quiet_desel: assert property (s_desel |-> io_oe == 4'h0)
        else $error("lanes driven while deselected");
    a_drive_selected: assert property (io_oe != 4'h0 |-> !$past(cs_n, 5))
        else $error("lanes driven without select");
    a_lane_groups: assert property (io_oe inside {4'h0, 4'h3, 4'hf})
        else $error("odd lane enable group");
    a_out_on_fall: assert property (io_oe != 4'h0 && $past(io_oe) != 4'h0 && $changed(io_out) |-> since_fall_r <= 4'h8)
        else $error("data changed away from a falling edge");
    a_addr_step: assert property (io_oe != 4'h0 && $past(io_oe) != 4'h0 && $changed(mem_raddr) |->
        mem_raddr == $past(mem_raddr) + 24'h1 || (mem_raddr[2:0] == 3'h0 && mem_raddr[23:8] == $past(mem_raddr[23:8])))
        else $error("read address step wrong");
endmodule

/* File: mfr_host_model.sv */
// host flash controller model: select, serial clock and io lanes
// assumes calls start right after an hclk edge; link times are absolute delays
module mfr_host_model (
    input  wire logic       hclk,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe,
    output logic            sclk,
    output logic            cs_n,
    output logic [3:0]      io_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] host_io;
    logic [3:0] host_oe;
    logic       float_r;
    logic       oe_seen;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        host_io = 4'h0;
        host_oe = 4'h0;
        float_r = 1'b0;
        oe_seen = 1'b0;
    end
    // undriven lanes toggle so a stale level never passes for data
    always @(posedge hclk) float_r <= !float_r;
    always @(posedge hclk) if (|io_oe) oe_seen <= 1'b1;
    always_comb for (int i = 0; i < 4; i++) io_in[i] = io_oe[i] ? io_out[i] : (host_oe[i] ? host_io[i] : float_r);
    function automatic logic [3:0] lmask(input int lanes);
        return (lanes == 4) ? 4'hf : ((lanes == 2) ? 4'h3 : 4'h1);
    endfunction
    task automatic frame_start();
        #1;
        oe_seen = 1'b0;
        cs_n = 1'b0;
        #40;
    endtask
    task automatic send(input logic [31:0] v, input int nclk, input int lanes, input logic rel);
        host_oe = lmask(lanes);
        for (int i = nclk - 1; i >= 0; i--) begin
            host_io = 4'(v >> (i * lanes)) & lmask(lanes);
            #40 sclk = 1'b1;
            if (i == 0 && rel) host_oe = 4'h0;
            #40 sclk = 1'b0;
        end
    endtask
    task automatic recv(input int nclk, input int lanes, output logic [31:0] got);
        got = 32'h0;
        for (int i = 0; i < nclk; i++) begin
            #40 sclk = 1'b1;
            got = (got << lanes) | 32'(io_in & lmask(lanes));
            #40 sclk = 1'b0;
        end
    endtask
    task automatic frame_end();
        #40 cs_n = 1'b1;
        host_oe = 4'h0;
        #200;
    endtask
endmodule

/* File: mfr_engine_tb_top.sv */
// bench top for the fast-read engine: ahb tasks, array model, link scenarios
// assumes mfr_host_model plays the host; the checker is bound at the foot
module mfr_engine_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        sclk;
    logic        cs_n;
    logic [3:0]  io_in;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic [23:0] mem_raddr;
    logic [7:0]  mem_rdata;
    logic [31:0] d;
    logic [31:0] e;
    logic [23:0] ea;
    int          failures;
    int          total_checks;
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    mfr_engine dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
        .io_oe(io_oe), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata));
    mfr_host_model host (.hclk(hclk), .io_out(io_out), .io_oe(io_oe), .sclk(sclk), .cs_n(cs_n), .io_in(io_in));
    function automatic logic [7:0] exp_byte(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    function automatic logic [31:0] exp4(input logic [23:0] a);
        return {exp_byte(a), exp_byte(a + 24'h1), exp_byte(a + 24'h2), exp_byte(a + 24'h3)};
    endfunction
    // array model: one hclk latency, byte depends on two address bytes
    always @(posedge hclk) mem_rdata <= exp_byte(mem_raddr);
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic fast_out(input logic [7:0] op, input int lanes, input logic [23:0] a, output logic [31:0] g);
        host.frame_start();
        host.send({24'h0, op}, 8, 1, 1'b0);
        host.send({8'h0, a}, 24, 1, 1'b0);
        host.send(32'h0, 8, 1, 1'b1);
        host.recv(16 / lanes, lanes, g);
        host.frame_end();
    endtask
    task automatic qread(input int opclk, input logic [23:0] a, input logic [7:0] m, input int dum,
                         output logic [31:0] g);
        host.frame_start();
        if (opclk != 0) host.send(32'heb, opclk, 8 / opclk, 1'b0);
        host.send({8'h0, a}, 6, 4, 1'b0);
        host.send({24'h0, m}, 2, 4, dum == 0);
        if (dum != 0) host.send(32'h0, dum, 4, 1'b1);
        host.recv(8, 4, g);
        host.frame_end();
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        mem_rdata = 8'h0;
        failures = 0;
        total_checks = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0, d);
        chk("cfg reset", d, 32'h10);
        ahb(1'b0, 32'h4, 32'h0, d);
        chk("stat reset", d, 32'h0);
        ahb(1'b0, 32'h8, 32'h0, d);
        chk("unmapped", d, 32'h0);
        ahb(1'b1, 32'h0, 32'h372, d);
        ahb(1'b0, 32'h0, 32'h0, d);
        chk("cfg rw", d, 32'h372);
        ahb(1'b1, 32'h0, 32'h10, d);
        $display("test registers done");
        fast_out(8'h3b, 2, 24'h000010, d);
        chk("dual out", d, exp4(24'h000010) >> 16);
        fast_out(8'h6b, 4, 24'h000044, d);
        chk("quad out refused", {31'h0, host.oe_seen}, 32'h0);
        ahb(1'b1, 32'h0, 32'h11, d);
        fast_out(8'h6b, 4, 24'h0123fe, d);
        chk("quad out", d, exp4(24'h0123fe) >> 16);
        $display("test fast output done");
        host.frame_start();
        host.send(32'hbb, 8, 1, 1'b0);
        host.send(32'h001234, 12, 2, 1'b0);
        host.send(32'h2f, 4, 2, 1'b1);
        host.recv(8, 2, d);
        host.frame_end();
        chk("dual io", d, exp4(24'h001234) >> 16);
        ahb(1'b0, 32'h4, 32'h0, d);
        chk("skip armed", {28'h0, d[3:0]}, 32'h8);
        host.frame_start();
        host.send(32'h000040, 12, 2, 1'b0);
        host.send(32'hff, 4, 2, 1'b1);
        host.recv(4, 2, d);
        host.frame_end();
        chk("dual io no opcode", d, exp4(24'h000040) >> 24);
        ahb(1'b0, 32'h4, 32'h0, d);
        chk("skip cleared", {28'h0, d[3:0]}, 32'h0);
        fast_out(8'h3b, 2, 24'h000010, d);
        chk("opcode again", d, exp4(24'h000010) >> 16);
        $display("test dual io done");
        for (int w = 0; w < 5; w++) begin
            ahb(1'b1, 32'h0, (w < 4) ? 32'(1 + (w << 5)) : 32'h11, d);
            qread(8, 24'h00013e, 8'h00, 4, d);
            for (int i = 0; i < 4; i++) begin
                ea = (w == 4) ? 24'h13e + 24'(i) : (24'h13e & ~24'((8 << w) - 1)) | ((24'h13e + 24'(i)) & 24'((8 << w) - 1));
                e = {e[23:0], exp_byte(ea)};
            end
            chk("quad io wrap", d, e);
        end
        $display("test quad io wrap done");
        // wrap stays enabled here, yet this four-lane read must not wrap
        for (int p = 3; p >= 0; p--) begin
            ahb(1'b1, 32'h0, 32'(3 + (p << 8)), d);
            qread(2, 24'h00013e, 8'h00, 2 * p, d);
            chk("four-lane read", d, exp4(24'h00013e));
        end
        ahb(1'b1, 32'h0, 32'h80000303, d);
        ahb(1'b0, 32'h0, 32'h0, d);
        chk("reset instruction", d, 32'h3);
        qread(2, 24'h000200, 8'h20, 0, d);
        chk("four-lane arm", d, exp4(24'h000200));
        qread(0, 24'h000300, 8'hff, 0, d);
        chk("four-lane no opcode", d, exp4(24'h000300));
        ahb(1'b0, 32'h4, 32'h0, d);
        chk("four-lane skip cleared", {28'h0, d[3:0]}, 32'h0);
        // single-lane-only opcode sent in four-lane mode must be ignored
        host.frame_start();
        host.send(32'h3b, 2, 4, 1'b0);
        host.send(32'h0, 14, 4, 1'b1);
        host.recv(4, 4, d);
        host.frame_end();
        chk("four-lane 3b refused", {31'h0, host.oe_seen}, 32'h0);
        ahb(1'b1, 32'h0, 32'h10, d);
        qread(8, 24'h000300, 8'h00, 4, d);
        chk("quad io refused", {31'h0, host.oe_seen}, 32'h0);
        $display("test four-lane done");
        end_sim();
    end
    initial begin
        #200000;
        failures++;
        end_sim();
    end
endmodule
bind mfr_engine mfr_engine_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata));
